/* core/pack_topology_config.sv */
/*
  Pack topology configuration register with redundant-field voting, supply
  tap and block divider routing decode, balance alert masking and the
  settle delay inserted into alternate-mux scans.
  Assumes synchronous inputs on clock_i, a one-cycle read/write strobe port
  and a scan engine that pulses a request before sampling the top cell.
*/
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none


module pack_topology_config
  import pack_topology_pkg::*;
(
  input  wire logic                                  clock_i,
  input  wire logic                                  rst_n_i,
  input  wire logic                                  ce_i,
  input  wire logic [pack_topology_pkg::ADDR_WIDTH-1:0] addr_i,
  input  wire logic [pack_topology_pkg::DATA_WIDTH-1:0] write_data_i,
  input  wire logic                                  write_i,
  input  wire logic                                  read_i,
  output var  logic [pack_topology_pkg::DATA_WIDTH-1:0] read_data_o,
  input  wire logic                                  scan_request_i,
  input  wire logic                                  alternate_mux_select_i,
  output var  logic                                  sample_go_o,
  output var  logic                                  settle_busy_o,
  output var  pack_topology_pkg::supply_tap_mux_type supply_tap_mux_o,
  output var  pack_topology_pkg::block_route_type    block_route_o,
  output var  logic [pack_topology_pkg::SWITCH_COUNT-1:0] balance_switch_alert_mask_o,
  output var  logic                                  flex_enable_effective_o,
  output var  logic                                  flex_mismatch_o,
  output var  logic                                  cell_mismatch_o
);

  import pack_topology_pkg::*;

  topology_fields_type   fields;
  settle_state_type      state;
  settle_state_type      next_state;
  logic                  flex_effective;
  logic                  flex_differ;
  logic                  cell_differ;
  logic                  cell_supported;
  logic                  block_supported;
  logic                  delay_needed;
  logic                  timer_start;
  logic                  timer_busy;
  logic                  timer_done;
  logic [3:0]            cell_agreed;
  logic [SWITCH_COUNT-1:0] next_mask;
  supply_tap_mux_type    next_tap;
  block_route_type       next_route;
  logic [SETTLE_WIDTH:0] wait_cycles;  // assertion helper

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  // stored fields; the reserved bit is never written
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fields.flex_pack_enable_b    <= FLEX_RESET;
      fields.flex_pack_enable_a    <= FLEX_RESET;
      fields.settle_delay_enable   <= SETTLE_EN_RESET;
      fields.reserved              <= 1'b0;
      fields.block_tap_select      <= BLOCK_SEL_RESET;
      fields.highest_cell_select_b <= CELL_SEL_RESET;
      fields.highest_cell_select_a <= CELL_SEL_RESET;
    end else if (ce_i && write_i && addr_i == PACK_TOPOLOGY_OFFSET) begin
      fields.flex_pack_enable_b    <= write_data_i[FLEX_B_POS];
      fields.flex_pack_enable_a    <= write_data_i[FLEX_A_POS];
      fields.settle_delay_enable   <= write_data_i[SETTLE_EN_POS];
      fields.reserved              <= 1'b0;
      fields.block_tap_select      <= write_data_i[BLOCK_SEL_LSB +: 4];
      fields.highest_cell_select_b <= write_data_i[CELL_B_LSB +: 4];
      fields.highest_cell_select_a <= write_data_i[CELL_A_LSB +: 4];
    end
  end

  // read data stand one cycle after the strobe; other addresses read zero
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      read_data_o <= '0;
    end else if (ce_i) begin
      if (read_i && addr_i == PACK_TOPOLOGY_OFFSET) begin
        read_data_o <= fields;
      end else begin
        read_data_o <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // voting on redundant fields
  // ----------------------------------------------------------------------
  // disagreeing enable copies fall back to enabled
  assign flex_differ    = fields.flex_pack_enable_a != fields.flex_pack_enable_b;
  assign flex_effective = flex_differ ? 1'b1 : fields.flex_pack_enable_a;
  assign cell_differ    = fields.highest_cell_select_a != fields.highest_cell_select_b;
  assign cell_agreed    = fields.highest_cell_select_a;
  assign cell_supported = !cell_differ && cell_agreed >= TAP_LOW
                          && cell_agreed <= TAP_HIGH;
  assign block_supported = fields.block_tap_select >= TAP_LOW
                           && fields.block_tap_select <= TAP_HIGH;

  // ----------------------------------------------------------------------
  // supply tap decode
  // ----------------------------------------------------------------------
  // one switch closes for a valid agreed top cell with both flex enable copies set, else the OFF position
  always_comb begin
    next_tap               = '0;
    next_tap.common_switch = 1'b1;
    next_tap.off_position  = 1'b1;
    if (flex_effective && !flex_differ && cell_supported) begin
      next_tap.common_switch = 1'b0;
      next_tap.off_position  = 1'b0;
      next_tap.switch_select = TAP_SWITCHES'(1) << (cell_agreed - TAP_LOW);
    end
  end

  // ----------------------------------------------------------------------
  // block divider decode
  // ----------------------------------------------------------------------
  // unsupported taps and a disabled flex pack fall back to the block pin
  always_comb begin
    next_route.tap       = BLOCK_PIN_CODE;
    next_route.block_pin = 1'b1;
    if (flex_effective && block_supported) begin
      next_route.tap       = fields.block_tap_select;
      next_route.block_pin = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // balance alert masking
  // ----------------------------------------------------------------------
  // switches above the agreed top cell are masked, independent of flex enable
  generate
    for (genvar i = 0; i < SWITCH_COUNT; i++) begin : g_mask
      assign next_mask[i] = !cell_differ && (5'(i + 1) > {1'b0, cell_agreed});
    end
  endgenerate

  // registered decode outputs
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      supply_tap_mux_o            <= '{switch_select: '0, common_switch: 1'b1, off_position: 1'b1};
      block_route_o               <= '{tap: BLOCK_PIN_CODE, block_pin: 1'b1};
      balance_switch_alert_mask_o <= '0;
      flex_enable_effective_o     <= FLEX_RESET;
      flex_mismatch_o             <= 1'b0;
      cell_mismatch_o             <= 1'b0;
    end else if (ce_i) begin
      supply_tap_mux_o            <= next_tap;
      block_route_o               <= next_route;
      balance_switch_alert_mask_o <= next_mask;
      flex_enable_effective_o     <= flex_effective;
      flex_mismatch_o             <= flex_differ;
      cell_mismatch_o             <= cell_differ;
    end
  end

  // ----------------------------------------------------------------------
  // settle delay sequencing
  // ----------------------------------------------------------------------
  // delay only in qualifying alternate-mux scans with the settle bit set
  assign delay_needed = fields.settle_delay_enable && flex_effective
                        && cell_supported && alternate_mux_select_i;
  assign timer_start  = state == SCAN_IDLE && scan_request_i && delay_needed;
  assign settle_busy_o = state == SCAN_SETTLE;

  // next state of the sequencer
  always_comb begin
    next_state = state;
    case (state)
      SCAN_IDLE: begin
        if (timer_start) begin
          next_state = SCAN_SETTLE;
        end
      end
      SCAN_SETTLE: begin
        if (timer_done) begin
          next_state = SCAN_IDLE;
        end
      end
      default: begin
        next_state = SCAN_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= SCAN_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // sample go: next cycle when no delay, after the timer otherwise
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sample_go_o <= 1'b0;
    end else if (ce_i) begin
      sample_go_o <= (state == SCAN_IDLE && scan_request_i && !delay_needed)
                     || (state == SCAN_SETTLE && timer_done);
    end
  end

  settle_timer #(
    .WIDTH  (SETTLE_WIDTH),
    .CYCLES (SETTLE_CYCLES)
  ) u_settle_timer (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .start_i (timer_start),
    .busy_o  (timer_busy),
    .done_o  (timer_done)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // enabled cycles spent settling, for the delay check
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wait_cycles <= '0;
    end else if (ce_i) begin
      if (state == SCAN_SETTLE) begin
        wait_cycles <= wait_cycles + (SETTLE_WIDTH+1)'(1);
      end else begin
        wait_cycles <= '0;
      end
    end
  end

  a_flex_vote_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && flex_differ |=> supply_tap_mux_o.off_position && flex_enable_effective_o)
    else $error("flex enable mismatch did not force supply tap off");

  a_reset_defaults: assert property (@(posedge clock_i)
    !rst_n_i |=> fields.flex_pack_enable_a && fields.flex_pack_enable_b
                 && fields.settle_delay_enable)
    else $error("flex or settle bits not set after reset");

  a_tap_select_one: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && fields.flex_pack_enable_a && fields.flex_pack_enable_b && cell_supported
    |=> supply_tap_mux_o.switch_select == (TAP_SWITCHES'(1) << ($past(cell_agreed) - TAP_LOW))
        && !supply_tap_mux_o.common_switch)
    else $error("supported top cell did not close its tap switch");

  a_tap_off_unsup: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !cell_supported |=> supply_tap_mux_o.switch_select == '0
                                && supply_tap_mux_o.common_switch)
    else $error("unsupported top cell left a tap switch closed");

  a_block_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !block_supported |=> block_route_o.block_pin && block_route_o.tap == BLOCK_PIN_CODE)
    else $error("unsupported block tap not routed to block pin");

  a_block_flex_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !flex_effective |=> block_route_o.block_pin)
    else $error("block field used while flex pack disabled");

  a_settle_length: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && state == SCAN_SETTLE && timer_done |=> sample_go_o && $past(wait_cycles) >= SETTLE_CYCLES)
    else $error("settle wait shorter than required");

  a_no_delay_path: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && state == SCAN_IDLE && scan_request_i && !delay_needed
    |=> sample_go_o && state == SCAN_IDLE)
    else $error("unqualified scan was delayed");

  a_settle_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !fields.settle_delay_enable && state == SCAN_IDLE |=> state == SCAN_IDLE)
    else $error("settle entered with settle bit clear");

  a_cell_vote_mask: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && cell_differ |=> balance_switch_alert_mask_o == '0 && supply_tap_mux_o.off_position)
    else $error("top cell mismatch left masking or tap selection on");

  a_cell_f_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !cell_differ && cell_agreed == 4'hf
    |=> balance_switch_alert_mask_o == '0 && supply_tap_mux_o.off_position)
    else $error("top cell 0xf did not clear masking");

  a_mask_any_flex: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !cell_differ && cell_agreed == 4'h0 |=> balance_switch_alert_mask_o == '1)
    else $error("top cell masking not applied");

  a_readback: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && read_i && addr_i == PACK_TOPOLOGY_OFFSET |=> read_data_o == $past(fields))
    else $error("readback differs from stored fields");

  a_reserved_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    read_data_o[RESERVED_POS] == 1'b0)
    else $error("reserved bit read as one");

  // the timer is busy or pulsing done throughout the settle state, so a late request cannot restart it
  a_timer_tracks: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state == SCAN_SETTLE |-> timer_busy || timer_done)
    else $error("settle state without a running timer");

  a_busy_ignore: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && state == SCAN_SETTLE && !timer_done |=> state == SCAN_SETTLE && !sample_go_o)
    else $error("settle wait cut short");

  a_write_lands: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && write_i && addr_i == PACK_TOPOLOGY_OFFSET
    |=> fields == ($past(write_data_i) & ~(DATA_WIDTH'(1) << RESERVED_POS)))
    else $error("written word not stored");

  a_flex_off_tap: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !flex_effective |=> supply_tap_mux_o.off_position && supply_tap_mux_o.switch_select == '0)
    else $error("top cell drove supply tap with flex pack disabled");

  a_route_tap: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && flex_effective && block_supported
    |=> !block_route_o.block_pin && block_route_o.tap == $past(fields.block_tap_select))
    else $error("supported block tap not routed");

  a_mask_flex_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !flex_effective && !cell_differ && cell_agreed == TAP_LOW
    |=> balance_switch_alert_mask_o[7:0] == '0 && &balance_switch_alert_mask_o[SWITCH_COUNT-1:8])
    else $error("masking lost with flex pack disabled");

endmodule // pack_topology_config

`default_nettype wire

/* core/pack_topology_pkg.sv */
/*
  Package for the pack topology configuration block: register offset, field
  layout, reset values, decode constants, settle timing and carrier types.
  Assumes a 100 MHz core clock and a plain address/strobe register port.
*/
`default_nettype none

package pack_topology_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_WIDTH          = 8;
  localparam int unsigned DATA_WIDTH          = 16;
  localparam logic [7:0]  PACK_TOPOLOGY_OFFSET = 8'h18;

  // field positions inside the topology register
  localparam int unsigned FLEX_B_POS     = 15;
  localparam int unsigned FLEX_A_POS     = 14;
  localparam int unsigned SETTLE_EN_POS  = 13;
  localparam int unsigned RESERVED_POS   = 12;
  localparam int unsigned BLOCK_SEL_LSB  = 8;
  localparam int unsigned CELL_B_LSB     = 4;
  localparam int unsigned CELL_A_LSB     = 0;

  // reset values
  localparam logic        FLEX_RESET      = 1'b1;
  localparam logic        SETTLE_EN_RESET = 1'b1;
  localparam logic [3:0]  BLOCK_SEL_RESET = 4'hf;
  localparam logic [3:0]  CELL_SEL_RESET  = 4'hf;

  // ----------------------------------------------------------------------
  // decode constants
  // ----------------------------------------------------------------------
  localparam logic [3:0]  TAP_LOW         = 4'h8;  // lowest supported tap
  localparam logic [3:0]  TAP_HIGH        = 4'he;  // highest supported tap
  localparam logic [3:0]  BLOCK_PIN_CODE  = 4'hf;  // dedicated block pin
  localparam int unsigned SWITCH_COUNT    = 14;
  localparam int unsigned TAP_SWITCHES    = 7;     // switches 8 through 14

  // ----------------------------------------------------------------------
  // settle timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned SETTLE_TIME_NS  = 30000;
  localparam int unsigned SETTLE_CYCLES   =
    (SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned SETTLE_WIDTH    = 12;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       flex_pack_enable_b;
    logic       flex_pack_enable_a;
    logic       settle_delay_enable;
    logic       reserved;
    logic [3:0] block_tap_select;
    logic [3:0] highest_cell_select_b;
    logic [3:0] highest_cell_select_a;
  } topology_fields_type;

  typedef struct packed {
    logic [TAP_SWITCHES-1:0] switch_select;  // bit 0 is switch 8
    logic                    common_switch;
    logic                    off_position;
  } supply_tap_mux_type;

  typedef struct packed {
    logic [3:0] tap;        // 0xf means dedicated block pin
    logic       block_pin;
  } block_route_type;

  typedef enum logic [1:0] {
    SCAN_IDLE   = 2'b00,
    SCAN_SETTLE = 2'b01
  } settle_state_type;

endpackage

`default_nettype wire

/* core/settle_timer.sv */
/*
  Down counter that times the settle wait before the top-cell sample.
  Assumes start pulses arrive only while idle; state freezes with ce_i low.
*/
`timescale 1ns/10ps
`default_nettype none

module settle_timer #(
  parameter int unsigned WIDTH  = 12,
  parameter int unsigned CYCLES = 3000
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic start_i,
  output var  logic busy_o,
  output var  logic done_o
);

  logic [WIDTH-1:0] count;

  // ----------------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------------
  // load on start, count down while busy, pulse done after the last count
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      count  <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        count  <= WIDTH'(CYCLES - 1);
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (count == '0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count - WIDTH'(1);
        end
      end
    end
  end

endmodule // settle_timer

`default_nettype wire

/* tb/tb_pack_topology_config.sv */
/*
  Self-checking bench for the pack topology configuration block: register
  access, redundant-field voting, routing decode, alert masking, settle delay.
  Assumes the package constants and the one-cycle strobe register port.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_pack_topology_config;
  import pack_topology_pkg::*;

  // ----------------------------------------------------------------------
  // stimulus, observation and model state
  // ----------------------------------------------------------------------
  logic                    clock_i = 1'b0;
  logic                    rst_n_i = 1'b0;
  logic                    ce_i = 1'b1;
  logic [ADDR_WIDTH-1:0]   addr_i = '0;
  logic [DATA_WIDTH-1:0]   write_data_i = '0;
  logic                    write_i = 1'b0;
  logic                    read_i = 1'b0;
  logic                    scan_request_i = 1'b0;
  logic                    alternate_mux_select_i = 1'b0;
  logic [DATA_WIDTH-1:0]   read_data_o;
  logic                    sample_go_o;
  logic                    settle_busy_o;
  supply_tap_mux_type      supply_tap_mux_o;
  block_route_type         block_route_o;
  logic [SWITCH_COUNT-1:0] balance_switch_alert_mask_o;
  logic                    flex_enable_effective_o;
  logic                    flex_mismatch_o;
  logic                    cell_mismatch_o;
  logic [15:0]             model_reg;
  logic [31:0]             seed = 32'd11;
  int                      num_errors = 0;
  int                      checked = 0;

  always #5 clock_i = ~clock_i;

  pack_topology_config u_pack_topology_config (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .write_data_i(write_data_i),
    .write_i(write_i), .read_i(read_i), .read_data_o(read_data_o), .scan_request_i(scan_request_i),
    .alternate_mux_select_i(alternate_mux_select_i), .sample_go_o(sample_go_o), .settle_busy_o(settle_busy_o),
    .supply_tap_mux_o(supply_tap_mux_o), .block_route_o(block_route_o),
    .balance_switch_alert_mask_o(balance_switch_alert_mask_o), .flex_enable_effective_o(flex_enable_effective_o),
    .flex_mismatch_o(flex_mismatch_o), .cell_mismatch_o(cell_mismatch_o));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic results();
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // voted enable: copies that differ count as enabled
  function automatic logic flex_eff();
    return (model_reg[15] != model_reg[14]) ? 1'b1 : model_reg[14];
  endfunction

  // agreed copies with a supported top cell close one tap switch
  function automatic logic tap_ok();
    return flex_eff() && model_reg[15] == model_reg[14] && model_reg[7:4] == model_reg[3:0]
           && model_reg[3:0] >= 4'h8 && model_reg[3:0] <= 4'he;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    write_data_i <= d;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask

  // read, then confirm the data stands for one cycle only
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1 check("read_data", read_data_o, exp);
    @(posedge clock_i);
    #1 check("read_data_idle", read_data_o, 16'h0000);
  endtask

  task automatic check_outs();
    supply_tap_mux_type      e_mux;
    block_route_type         e_blk;
    logic [SWITCH_COUNT-1:0] e_mask;
    logic [3:0]              ca;
    logic                    cmis;
    ca = model_reg[3:0];
    cmis = model_reg[7:4] != ca;
    e_mux = '0;
    e_mux.common_switch = !tap_ok();
    e_mux.off_position = !tap_ok();
    if (tap_ok()) e_mux.switch_select[ca - 4'h8] = 1'b1;
    e_blk.tap = (flex_eff() && model_reg[11:8] >= 4'h8 && model_reg[11:8] <= 4'he) ? model_reg[11:8] : 4'hf;
    e_blk.block_pin = e_blk.tap == 4'hf;
    for (int i = 0; i < SWITCH_COUNT; i++) e_mask[i] = !cmis && ca != 4'hf && (i + 1 > ca);
    check("flex_effective", flex_enable_effective_o, flex_eff());
    check("flex_mismatch", flex_mismatch_o, model_reg[15] != model_reg[14]);
    check("cell_mismatch", cell_mismatch_o, cmis);
    check("supply_tap_mux", supply_tap_mux_o, e_mux);
    check("block_route", block_route_o, e_blk);
    check("alert_mask", balance_switch_alert_mask_o, e_mask);
  endtask

  task automatic wr_chk(input logic [15:0] d);
    wr(PACK_TOPOLOGY_OFFSET, d);
    model_reg = d & 16'hefff;
    repeat (2) @(posedge clock_i);
    #1 check_outs();
    rd_chk(PACK_TOPOLOGY_OFFSET, model_reg);
  endtask

  // one scan request; a second request mid-delay must be ignored
  task automatic scan(input logic alt);
    int   n;
    logic dly;
    // voted enable, agreed supported top cell and alternate mux; tap OFF does not matter
    dly = model_reg[SETTLE_EN_POS] && flex_eff() && model_reg[7:4] == model_reg[3:0]
          && model_reg[3:0] >= 4'h8 && model_reg[3:0] <= 4'he && alt;
    @(posedge clock_i);
    scan_request_i <= 1'b1;
    alternate_mux_select_i <= alt;
    @(posedge clock_i);
    scan_request_i <= 1'b0;
    #1 check("settle_busy", settle_busy_o, dly);
    n = 0;
    while (sample_go_o !== 1'b1 && n < 4000) begin
      if (n == 10) scan_request_i <= 1'b1;
      if (n == 11) scan_request_i <= 1'b0;
      @(posedge clock_i);
      #1 n++;
    end
    // delayed go comes one cycle after the full settle count has elapsed
    check("sample_latency", n, dly ? SETTLE_CYCLES + 1 : 0);
    repeat (3) begin
      @(posedge clock_i);
      #1 check("sample_go_once", sample_go_o, 1'b0);
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  localparam logic [15:0] SCAN_WORDS [9] = '{16'hef88, 16'heeee, 16'hefaa, 16'hcfaa,
                                             16'hefff, 16'hef77, 16'h2faa, 16'hef8a, 16'haf99};
  localparam logic        SCAN_ALT   [9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    model_reg = 16'hefff;
    #1 check_outs();
    rd_chk(PACK_TOPOLOGY_OFFSET, 16'hefff);
    // unmapped place: write ignored, read returns zero
    wr(8'h19, 16'h0000);
    rd_chk(8'h19, 16'h0000);
    rd_chk(PACK_TOPOLOGY_OFFSET, model_reg);
    // frozen clock enable drops a write
    ce_i <= 1'b0;
    wr(PACK_TOPOLOGY_OFFSET, 16'h0000);
    ce_i <= 1'b1;
    rd_chk(PACK_TOPOLOGY_OFFSET, model_reg);
    // every top-cell and block value, flexible pack on then off
    for (int v = 0; v < 16; v++) begin
      wr_chk(16'he000 | 16'(v * 16'h0111));
      wr_chk(16'h3000 | 16'(v * 16'h0111));
    end
    for (int k = 0; k < 40; k++) wr_chk(16'(xs() >> 7));
    for (int k = 0; k < 9; k++) begin
      wr_chk(SCAN_WORDS[k]);
      scan(SCAN_ALT[k]);
    end
    results();
  end

  initial begin
    repeat (30000) @(posedge clock_i);
    num_errors++;
    results();
  end
endmodule // tb_pack_topology_config

`default_nettype wire
